// *** shared/phy_link_pkg.sv ***
/*
 * Shared constants, types and speed-code helpers for the physical-layer to
 * link-controller parallel handshake.
 * Assumes both ends sample on the rising edge of the interface clock that
 * the physical-layer end supplies; bit 7 of the data bus carries data line 0.
 */
package phy_link_pkg;

	// ------------------------------------------------------------
	// Control-line states
	// ------------------------------------------------------------
	localparam logic [1:0] CTL_IDLE     = 2'h0;
	localparam logic [1:0] CTL_STATUS   = 2'h1;
	localparam logic [1:0] CTL_RECEIVE  = 2'h2;
	localparam logic [1:0] CTL_GRANT    = 2'h3;
	localparam logic [1:0] CTL_HOLD     = 2'h1;
	localparam logic [1:0] CTL_TRANSMIT = 2'h2;

	// ------------------------------------------------------------
	// Data-line codes
	// ------------------------------------------------------------
	localparam logic [7:0] D_DATA_ON   = 8'hff;
	localparam logic [7:0] D_ZERO      = 8'h00;
	localparam logic [7:0] SPD_CODE100 = 8'h00;
	localparam logic [7:0] SPD_CODE200 = 8'h40;
	localparam logic [7:0] SPD_CODE400 = 8'h50;

	typedef enum logic [1:0] {
		SPD_S100 = 2'h0,
		SPD_S200 = 2'h1,
		SPD_S400 = 2'h2,
		SPD_BAD  = 2'h3
	} speed_t;

	// ------------------------------------------------------------
	// Counts and times
	// ------------------------------------------------------------
	localparam logic [5:0] HOLD_MAX_CNT   = 6'h2f;
	localparam logic [3:0] STAT_SHORT_CYC = 4'h2;
	localparam logic [3:0] STAT_LONG_CYC  = 4'h8;
	localparam logic [7:0] LINK_SETTLE    = 8'h02;
	localparam int         PCLK_NS        = 48;
	localparam int         PKT_SEP_NS     = 400;
	localparam logic [7:0] PKT_SEP_CYC    = 8'((PKT_SEP_NS + PCLK_NS - 1) / PCLK_NS);

	// ------------------------------------------------------------
	// Speed-code helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] speedCode(input speed_t sp);
		unique case (sp)
			SPD_S200: speedCode = SPD_CODE200;
			SPD_S400: speedCode = SPD_CODE400;
			default:  speedCode = SPD_CODE100;
		endcase
	endfunction

	function automatic speed_t speedDecode(input logic [7:0] d);
		if (d[7:6] == 2'h0)
			speedDecode = SPD_S100;
		else if (d[7:4] == 4'h4)
			speedDecode = SPD_S200;
		else if (d == SPD_CODE400)
			speedDecode = SPD_S400;
		else
			speedDecode = SPD_BAD;
	endfunction

endpackage

// *** shared/phy_link_if.sv ***
/*
 * Parallel interface between the physical-layer end and the link end.
 * Assumes the bench supplies the interface clock; undriven lines read low.
 */
`timescale 1ns/1ps
interface phy_link_if (
	input wire logic pclk
);
	logic [1:0] ctlPhy;
	logic [7:0] dPhy;
	logic       oePhy;
	logic [1:0] ctlLink;
	logic [7:0] dLink;
	logic       oeLink;
	logic       lreq;
	logic [1:0] ctl;
	logic [7:0] d;

	// Resolved wire level, bus holder modelled as low
	assign ctl = oePhy ? ctlPhy : (oeLink ? ctlLink : 2'h0);
	assign d   = oePhy ? dPhy : (oeLink ? dLink : 8'h00);

	modport phy_mp (
		input  pclk,
		input  ctl,
		input  d,
		input  lreq,
		output ctlPhy,
		output dPhy,
		output oePhy
	);

	modport link_mp (
		input  pclk,
		input  ctl,
		input  d,
		output ctlLink,
		output dLink,
		output oeLink,
		output lreq
	);
endinterface

// *** design/phy_end.sv ***
/*
 * Physical-layer end of the parallel handshake: status transfer, packet
 * reception, grant and handover for link transmit, concatenation.
 * Assumes it runs on the interface clock and that the serial-bus side
 * presents receive data one byte per clock once the speed is known.
 */
// Summary of operation
// - Receive starts on control; may interrupt status.
// - Data-on code may precede speed code.
// - Speed code exactly one cycle before data.
// - Link takes speed from first non-data-on cycle.
// - Link discards packet on bad or excessive speed.
// - Receive holds during data; idle after end.
// - Null packet: data-on then idle only.
// - Won arbitration: grant one clock, idle one.
// - Link states idle 00, hold 01, transmit 10.
// - After grant idle, release control and data.
// - Link drives at most one idle first.
// - Link holds at most 47 cycles.
// - Link hold before transmit gives data prefix.
// - Link transmit carries data until last.
// - Link ends: hold/idle, idle, then release.
// - Ending hold: wait separation, grant again.
// - Without multispeed, concatenated packets keep speed.
// - Multispeed: next speed on terminating hold.
// - No S100 packet after faster packet.
// - Drive idle one clock after sampling release.
// - One idle before any new operation.
// - Status two bits a cycle, 2 or 8.
`timescale 1ns/1ps
module phy_end
	import phy_link_pkg::*;
(
	// Interface and reset
	phy_link_if.phy_mp     port,
	input  wire logic      nrst,
	// Status source
	input  wire logic      statStart,
	input  wire logic      statLong,
	input  wire logic [15:0] statWord,
	output logic           statReady,
	// Serial receive side
	input  wire logic      rxPrefix,
	input  wire logic      rxSpeedValid,
	input  wire speed_t    rxSpeed,
	input  wire logic      rxDataValid,
	input  wire logic [7:0] rxData,
	// Serial transmit side
	input  wire logic      arbWon,
	input  wire speed_t    grantSpeed,
	input  wire logic      multispeedEnable,
	output logic           busRequest,
	output logic           txPrefix,
	output logic           txValid,
	output logic [7:0]     txData,
	output speed_t         txSpeed
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		P_IDLE  = 3'h0,
		P_STAT  = 3'h1,
		P_RXON  = 3'h2,
		P_RXDAT = 3'h3,
		P_GRANT = 3'h4,
		P_GIDLE = 3'h5,
		P_LINK  = 3'h6,
		P_SEP   = 3'h7
	} phy_state_t;

	typedef struct packed {
		phy_state_t  state;
		logic [1:0]  ctlIn;
		logic [7:0]  dIn;
		logic        lreq;
		logic [1:0]  ctlOut;
		logic [7:0]  dOut;
		logic        oe;
		logic        idleOk;
		logic        pendGrant;
		logic [7:0]  cnt;
		logic [13:0] stat;
		logic        sawTx;
		logic        ended;
		logic        prevIdle;
		logic        endHold;
		speed_t      speed;
		logic        txPrefix;
		logic        txValid;
		logic [7:0]  txData;
	} phy_regs_t;

	phy_regs_t s_q;
	phy_regs_t s_d;

	logic canStart;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d          = s_q;
		s_d.ctlIn    = port.ctl;
		s_d.dIn      = port.d;
		s_d.lreq     = port.lreq;
		s_d.txPrefix = 1'b0;
		s_d.txValid  = 1'b0;
		canStart     = (s_q.state == P_IDLE) && s_q.idleOk;
		s_d.pendGrant = arbWon | s_q.pendGrant;
		statReady    = canStart && !rxPrefix && !s_q.pendGrant;

		unique case (s_q.state)
			P_IDLE:
			begin
				s_d.ctlOut = CTL_IDLE;
				s_d.dOut   = D_ZERO;
				s_d.oe     = 1'b1;
				s_d.idleOk = 1'b1;
				if (canStart && rxPrefix)
				begin
					s_d.state  = P_RXON;
					s_d.ctlOut = CTL_RECEIVE;
					s_d.dOut   = D_DATA_ON;
				end
				else if (canStart && s_q.pendGrant)
				begin
					s_d.state     = P_GRANT;
					s_d.ctlOut    = CTL_GRANT;
					s_d.pendGrant = arbWon;
					s_d.speed     = grantSpeed;
				end
				else if (statReady && statStart)
				begin
					s_d.state  = P_STAT;
					s_d.ctlOut = CTL_STATUS;
					s_d.dOut   = {statWord[0], statWord[1], 6'h00};
					s_d.stat   = statWord[15:2];
					s_d.cnt    = {4'h0, statLong ? STAT_LONG_CYC : STAT_SHORT_CYC} - 8'h01;
				end
			end
			P_STAT:
			begin
				if (rxPrefix)
				begin
					s_d.state  = P_RXON;
					s_d.ctlOut = CTL_RECEIVE;
					s_d.dOut   = D_DATA_ON;
				end
				else if (s_q.cnt == 8'h00)
				begin
					s_d.state  = P_IDLE;
					s_d.ctlOut = CTL_IDLE;
					s_d.dOut   = D_ZERO;
				end
				else
				begin
					s_d.dOut = {s_q.stat[0], s_q.stat[1], 6'h00};
					s_d.stat = {2'h0, s_q.stat[13:2]};
					s_d.cnt  = s_q.cnt - 8'h01;
				end
			end
			P_RXON:
			begin
				if (!rxPrefix)
				begin
					s_d.state  = P_IDLE;
					s_d.ctlOut = CTL_IDLE;
					s_d.dOut   = D_ZERO;
				end
				else if (rxSpeedValid)
				begin
					s_d.state = P_RXDAT;
					s_d.dOut  = speedCode(rxSpeed);
				end
			end
			P_RXDAT:
			begin
				if (!rxPrefix)
				begin
					s_d.state  = P_IDLE;
					s_d.ctlOut = CTL_IDLE;
					s_d.dOut   = D_ZERO;
				end
				else if (rxDataValid)
					s_d.dOut = rxData;
			end
			P_GRANT:
			begin
				s_d.state  = P_GIDLE;
				s_d.ctlOut = CTL_IDLE;
			end
			P_GIDLE:
			begin
				s_d.state    = P_LINK;
				s_d.oe       = 1'b0;
				s_d.cnt      = LINK_SETTLE;
				s_d.sawTx    = 1'b0;
				s_d.ended    = 1'b0;
				s_d.prevIdle = 1'b0;
				s_d.endHold  = 1'b0;
			end
			P_LINK:
			begin
				if (s_q.cnt != 8'h00)
					s_d.cnt = s_q.cnt - 8'h01;
				else
				begin
					s_d.prevIdle = (s_q.ctlIn == CTL_IDLE);
					if (s_q.ctlIn == CTL_TRANSMIT)
					begin
						s_d.sawTx   = 1'b1;
						s_d.txValid = 1'b1;
						s_d.txData  = s_q.dIn;
					end
					else if (s_q.sawTx && !s_q.ended)
					begin
						s_d.ended   = 1'b1;
						s_d.endHold = (s_q.ctlIn == CTL_HOLD);
						if (s_q.ctlIn == CTL_HOLD && multispeedEnable &&
							speedDecode(s_q.dIn) != SPD_BAD)
							s_d.speed = speedDecode(s_q.dIn);
					end
					else if (s_q.ctlIn == CTL_HOLD && !s_q.sawTx)
						s_d.txPrefix = 1'b1;
					if (s_q.ctlIn == CTL_IDLE && (s_q.prevIdle || s_q.ended))
					begin
						s_d.oe     = 1'b1;
						s_d.ctlOut = CTL_IDLE;
						s_d.dOut   = D_ZERO;
						s_d.cnt    = PKT_SEP_CYC;
						s_d.state  = s_d.endHold ? P_SEP : P_IDLE;
					end
				end
			end
			P_SEP:
			begin
				if (s_q.cnt > 8'h01)
					s_d.cnt = s_q.cnt - 8'h01;
				else
				begin
					s_d.state  = P_GRANT;
					s_d.ctlOut = CTL_GRANT;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge port.pclk)
	begin
		if (!nrst)
		begin
			s_q       <= '0;
			s_q.state <= P_IDLE;
			s_q.speed <= SPD_S100;
		end
		else
			s_q <= s_d;
	end

	assign port.ctlPhy = s_q.ctlOut;
	assign port.dPhy   = s_q.dOut;
	assign port.oePhy  = s_q.oe;
	assign busRequest  = s_q.lreq;
	assign txPrefix    = s_q.txPrefix;
	assign txValid     = s_q.txValid;
	assign txData      = s_q.txData;
	assign txSpeed     = s_q.speed;

endmodule // phy_end

// *** design/link_end.sv ***
/*
 * Link-controller end of the parallel handshake: bus request, hold and
 * transmit, packet end and concatenation, receive speed check.
 * Assumes the interface clock comes from the physical-layer end; control
 * levels from the core domain are quasi-static while a packet is in flight.
 */
`timescale 1ns/1ps
module link_end
	import phy_link_pkg::*;
(
	// Core domain
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       txGo,
	input  wire logic       multispeedEnable,
	input  wire speed_t     maxSpeed,
	output logic            txDone,
	output logic            rxDone,
	output logic            busy,
	// Interface
	phy_link_if.link_mp     port,
	// Transmit stream, interface clock
	input  wire logic       txValid,
	input  wire logic [7:0] txData,
	input  wire logic       txLast,
	input  wire speed_t     txSpeed,
	input  wire logic       txConcat,
	input  wire speed_t     txNextSpeed,
	output logic            txReady,
	// Receive stream, interface clock
	output logic            rxValid,
	output logic [7:0]      rxData,
	output speed_t          rxSpeed
);

	// ------------------------------------------------------------
	// Interface-clock state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		L_IDLE  = 3'h0,
		L_REQ   = 3'h1,
		L_TAKE  = 3'h2,
		L_HOLD  = 3'h3,
		L_TX    = 3'h4,
		L_LAST  = 3'h5,
		L_END   = 3'h6,
		L_REL   = 3'h7
	} link_state_t;

	typedef struct packed {
		link_state_t state;
		logic [1:0]  rstSync;
		logic [1:0]  ctlIn;
		logic [7:0]  dIn;
		logic [1:0]  ctlOut;
		logic [7:0]  dOut;
		logic        oe;
		logic        lreq;
		logic        concat;
		logic [5:0]  holdCnt;
		speed_t      curSpeed;
		logic [2:0]  goSync;
		logic [1:0]  msSync;
		logic [3:0]  maxSync;
		logic        rxAct;
		logic        rxSpdSeen;
		logic        rxKeep;
		logic        rxValid;
		logic [7:0]  rxData;
		speed_t      rxSpeed;
		logic        doneTog;
		logic        rxTog;
	} link_regs_t;

	// Core-clock state
	typedef struct packed {
		logic       goTog;
		logic [2:0] doneSync;
		logic [2:0] rxSync;
		logic [1:0] busySync;
		logic       txDone;
		logic       rxDone;
	} core_regs_t;

	link_regs_t s_q;
	link_regs_t s_d;
	core_regs_t c_q;
	core_regs_t c_d;

	logic   lnkRstN;
	speed_t spIn;

	assign lnkRstN = s_q.rstSync[1];

	// ------------------------------------------------------------
	// Interface-clock logic
	// ------------------------------------------------------------
	always_comb
	begin
		s_d         = s_q;
		s_d.ctlIn   = port.ctl;
		s_d.dIn     = port.d;
		s_d.rstSync = {s_q.rstSync[0], nrst};
		s_d.goSync  = {s_q.goSync[1:0], c_q.goTog};
		s_d.msSync  = {s_q.msSync[0], multispeedEnable};
		s_d.maxSync = {s_q.maxSync[1:0], maxSpeed};
		s_d.rxValid = 1'b0;
		txReady     = (s_q.state == L_HOLD) || (s_q.state == L_TX);
		spIn        = speedDecode(s_q.dIn);

		// Receive path, only while the far end owns the lines
		if (!s_q.oe && s_q.ctlIn == CTL_RECEIVE)
		begin
			s_d.rxAct = 1'b1;
			if (!s_q.rxSpdSeen && s_q.dIn != D_DATA_ON)
			begin
				s_d.rxSpdSeen = 1'b1;
				s_d.rxSpeed   = spIn;
				s_d.rxKeep    = (spIn != SPD_BAD) &&
					(spIn <= speed_t'(s_q.maxSync[3:2]));
			end
			else if (s_q.rxSpdSeen && s_q.rxKeep)
			begin
				s_d.rxValid = 1'b1;
				s_d.rxData  = s_q.dIn;
			end
		end
		else if (s_q.rxAct)
		begin
			s_d.rxAct     = 1'b0;
			s_d.rxSpdSeen = 1'b0;
			s_d.rxKeep    = 1'b0;
			s_d.rxTog     = ~s_q.rxTog;
		end

		unique case (s_q.state)
			L_IDLE:
			begin
				if (s_q.goSync[2] != s_q.goSync[1])
				begin
					s_d.state    = L_REQ;
					s_d.lreq     = 1'b1;
					s_d.curSpeed = txSpeed;
				end
			end
			L_REQ:
			begin
				if (!s_q.oe && s_q.ctlIn == CTL_GRANT)
				begin
					s_d.state = L_TAKE;
					s_d.lreq  = 1'b0;
				end
			end
			L_TAKE:
			begin
				s_d.state   = L_HOLD;
				s_d.oe      = 1'b1;
				s_d.ctlOut  = CTL_HOLD;
				s_d.dOut    = D_ZERO;
				s_d.holdCnt = 6'h01;
				s_d.concat  = 1'b0;
			end
			L_HOLD:
			begin
				if (txValid)
				begin
					s_d.state  = txLast ? L_LAST : L_TX;
					s_d.ctlOut = CTL_TRANSMIT;
					s_d.dOut   = txData;
				end
				else if (s_q.holdCnt == HOLD_MAX_CNT)
				begin
					s_d.state  = L_END;
					s_d.ctlOut = CTL_IDLE;
					s_d.dOut   = D_ZERO;
				end
				else
					s_d.holdCnt = s_q.holdCnt + 6'h01;
			end
			L_TX:
			begin
				s_d.dOut = txData;
				if (txValid && txLast)
					s_d.state = L_LAST;
			end
			L_LAST:
			begin
				s_d.state  = L_END;
				s_d.ctlOut = CTL_IDLE;
				s_d.dOut   = D_ZERO;
				if (txConcat && !(s_q.msSync[1] && txNextSpeed == SPD_S100 &&
					s_q.curSpeed != SPD_S100))
				begin
					s_d.concat = 1'b1;
					s_d.ctlOut = CTL_HOLD;
					if (s_q.msSync[1])
					begin
						s_d.dOut     = speedCode(txNextSpeed);
						s_d.curSpeed = txNextSpeed;
					end
				end
			end
			L_END:
			begin
				s_d.state  = L_REL;
				s_d.ctlOut = CTL_IDLE;
				s_d.dOut   = D_ZERO;
			end
			L_REL:
			begin
				s_d.oe    = 1'b0;
				s_d.state = s_q.concat ? L_REQ : L_IDLE;
				if (!s_q.concat)
					s_d.doneTog = ~s_q.doneTog;
			end
		endcase
	end

	always_ff @(posedge port.pclk)
	begin
		if (!lnkRstN)
		begin
			s_q          <= '0;
			s_q.state    <= L_IDLE;
			s_q.rstSync  <= {s_q.rstSync[0], nrst};
			s_q.goSync   <= {3{c_q.goTog}};
			s_q.curSpeed <= SPD_S100;
		end
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// Core-clock logic
	// ------------------------------------------------------------
	always_comb
	begin
		c_d          = c_q;
		c_d.goTog    = c_q.goTog ^ txGo;
		c_d.doneSync = {c_q.doneSync[1:0], s_q.doneTog};
		c_d.rxSync   = {c_q.rxSync[1:0], s_q.rxTog};
		c_d.busySync = {c_q.busySync[0], s_q.state != L_IDLE};
		c_d.txDone   = c_q.doneSync[2] ^ c_q.doneSync[1];
		c_d.rxDone   = c_q.rxSync[2] ^ c_q.rxSync[1];
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			c_q <= '0;
		else
			c_q <= c_d;
	end

	assign txDone       = c_q.txDone;
	assign rxDone       = c_q.rxDone;
	assign busy         = c_q.busySync[1];
	assign port.ctlLink = s_q.ctlOut;
	assign port.dLink   = s_q.dOut;
	assign port.oeLink  = s_q.oe;
	assign port.lreq    = s_q.lreq;
	assign rxValid      = s_q.rxValid;
	assign rxData       = s_q.rxData;
	assign rxSpeed      = s_q.rxSpeed;

endmodule // link_end

// *** testbench/phy_link_packet_handshake_asserts.sv ***
/*
 * Checker for the wire between the physical-layer end and the link end.
 * Assumes one interface clock domain, with nrst synchronous to it.
 */
`timescale 1ns/1ps
module phy_link_packet_handshake_asserts
	import phy_link_pkg::*;
(
	// Clock and reset
	input wire logic       pclk,
	input wire logic       nrst,
	// Physical-layer drive
	input wire logic [1:0] ctlPhy,
	input wire logic [7:0] dPhy,
	input wire logic       oePhy,
	// Link drive
	input wire logic [1:0] ctlLink,
	input wire logic [7:0] dLink,
	input wire logic       oeLink,
	input wire logic       lreq,
	// Resolved wire
	input wire logic [1:0] ctl,
	input wire logic [7:0] d
);
	// ------------------------------------------------------------
	// Hold run counter
	// ------------------------------------------------------------
	logic [5:0] holdCnt_q;

	always_ff @(posedge pclk)
	begin
		if (!nrst || !(oeLink && ctlLink == CTL_HOLD))
			holdCnt_q <= 6'h00;
		else if (holdCnt_q != 6'h3f)
			holdCnt_q <= holdCnt_q + 6'h01;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!nrst);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_grant;
		(oePhy && ctlPhy == CTL_GRANT) |=> (oePhy && ctlPhy == CTL_IDLE) ##1 !oePhy;
	endproperty
	a_grant: assert property (p_grant) else $error("grant handover wrong");

	property p_rx_on;
		(oePhy && ctl == CTL_RECEIVE && ($past(ctlPhy) != CTL_RECEIVE || !$past(oePhy)))
			|-> d == D_DATA_ON;
	endproperty
	a_rx_on: assert property (p_rx_on) else $error("receive without data-on");

	property p_spd;
		(oePhy && ctlPhy == CTL_RECEIVE && $past(ctlPhy) == CTL_RECEIVE
			&& $past(dPhy) == D_DATA_ON && dPhy != D_DATA_ON)
			|-> (d == SPD_CODE100 || d == SPD_CODE200 || d == SPD_CODE400)
			##1 (oePhy && ctlPhy == CTL_RECEIVE);
	endproperty
	a_spd: assert property (p_spd) else $error("bad speed code");

	property p_rx_end;
		(oePhy && $past(oePhy) && $past(ctlPhy) == CTL_RECEIVE && ctlPhy != CTL_RECEIVE)
			|-> ctlPhy == CTL_IDLE;
	endproperty
	a_rx_end: assert property (p_rx_end) else $error("receive not ended by idle");

	property p_regain;
		$fell(oeLink) |-> ##[1:3] (oePhy && ctlPhy == CTL_IDLE);
	endproperty
	a_regain: assert property (p_regain) else $error("no idle after release");

	property p_first_idle;
		$rose(oePhy) |-> ctlPhy == CTL_IDLE;
	endproperty
	a_first_idle: assert property (p_first_idle) else $error("no idle on regain");

	property p_turn;
		$fell(oePhy) |-> !oeLink ##1 oeLink;
	endproperty
	a_turn: assert property (p_turn) else $error("turnaround wrong");

	property p_clash;
		!(oePhy && oeLink);
	endproperty
	a_clash: assert property (p_clash) else $error("both ends drive");

	property p_link_start;
		$rose(oeLink) |-> ##[0:1] (ctlLink == CTL_HOLD || ctlLink == CTL_TRANSMIT);
	endproperty
	a_link_start: assert property (p_link_start) else $error("link idles too long");

	property p_hold_max;
		holdCnt_q <= HOLD_MAX_CNT;
	endproperty
	a_hold_max: assert property (p_hold_max) else $error("hold too long");

	property p_tx_end;
		(oeLink && $past(oeLink) && $past(ctlLink) == CTL_TRANSMIT && ctlLink != CTL_TRANSMIT)
			|-> (ctlLink == CTL_HOLD || ctlLink == CTL_IDLE)
			##1 (oeLink && ctlLink == CTL_IDLE) ##1 !oeLink;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("packet end wrong");

	property p_concat;
		($fell(oeLink) && $past(ctlLink, 2) == CTL_HOLD && $past(ctlLink, 3) == CTL_TRANSMIT)
			|-> (!(oePhy && ctlPhy == CTL_GRANT)) [*8] ##[1:24] (oePhy && ctlPhy == CTL_GRANT);
	endproperty
	a_concat: assert property (p_concat) else $error("concat grant wrong");
endmodule // phy_link_packet_handshake_asserts

// *** testbench/phy_link_packet_handshake_tb.sv ***
/*
 * Bench joining both ends of the handshake: receive, status, transmit.
 * Assumes the bench makes both clocks; the phy sees only the interface clock.
 */
`timescale 1ns/1ps
module phy_link_packet_handshake_tb
	import phy_link_pkg::*;
;
	logic pclk, core_clk, nrst, statStart, statLong, statReady, rxPrefix, rxSpeedValid;
	logic rxDataValid, arbWon, msc, busRequest, txPrefix, pTxValid, txGo, txDone;
	logic lTxValid, txLast, txConcat, txReady, rxValid, prevOe, rxDone, busy;
	logic [15:0] statWord;
	logic [7:0]  rxDataIn, pTxData, lTxData, lRxData, prevD;
	logic [1:0]  prevCtl;
	speed_t      rxSpeedIn, grantSpeed, pTxSpeed, lTxSpeed, txNextSpeed, lRxSpeed;
	logic [7:0]  rxGot[$], txGot[$], spdQ[$];
	logic [1:0]  statBits[$];
	logic        statToRx;
	int          miscompares, nTests, doneCnt, rxCnt;

	phy_link_if phy_link_if_i (.pclk(pclk));
	phy_end phy_end_i (.port(phy_link_if_i), .nrst(nrst), .statStart(statStart),
		.statLong(statLong), .statWord(statWord), .statReady(statReady),
		.rxPrefix(rxPrefix), .rxSpeedValid(rxSpeedValid), .rxSpeed(rxSpeedIn),
		.rxDataValid(rxDataValid), .rxData(rxDataIn), .arbWon(arbWon),
		.grantSpeed(grantSpeed), .multispeedEnable(msc), .busRequest(busRequest),
		.txPrefix(txPrefix), .txValid(pTxValid), .txData(pTxData), .txSpeed(pTxSpeed));
	link_end link_end_i (.core_clk(core_clk), .nrst(nrst), .txGo(txGo),
		.multispeedEnable(msc), .maxSpeed(SPD_S200), .txDone(txDone), .rxDone(rxDone),
		.busy(busy), .port(phy_link_if_i), .txValid(lTxValid), .txData(lTxData),
		.txLast(txLast), .txSpeed(lTxSpeed), .txConcat(txConcat),
		.txNextSpeed(txNextSpeed), .txReady(txReady), .rxValid(rxValid),
		.rxData(lRxData), .rxSpeed(lRxSpeed));
	phy_link_packet_handshake_asserts phy_link_packet_handshake_asserts_i (.pclk(pclk),
		.nrst(nrst), .ctlPhy(phy_link_if_i.ctlPhy), .dPhy(phy_link_if_i.dPhy),
		.oePhy(phy_link_if_i.oePhy), .ctlLink(phy_link_if_i.ctlLink),
		.dLink(phy_link_if_i.dLink), .oeLink(phy_link_if_i.oeLink),
		.lreq(phy_link_if_i.lreq), .ctl(phy_link_if_i.ctl), .d(phy_link_if_i.d));

	// ------------------------------------------------------------
	// Clocks and monitors
	// ------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		#5;
		forever #24 pclk = ~pclk;
	end
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		if (txDone === 1'b1)
			doneCnt++;
		if (rxDone === 1'b1)
			rxCnt++;
	end
	always @(posedge pclk)
	begin
		if (rxValid === 1'b1)
			rxGot.push_back(lRxData);
		if (pTxValid === 1'b1)
			txGot.push_back(pTxData);
		if (phy_link_if_i.oePhy === 1'b1 && phy_link_if_i.ctl === CTL_STATUS)
			statBits.push_back({phy_link_if_i.d[6], phy_link_if_i.d[7]});
		if (phy_link_if_i.oePhy === 1'b1 && prevOe === 1'b1 && prevCtl === CTL_STATUS
			&& phy_link_if_i.ctl === CTL_RECEIVE)
			statToRx = 1'b1;
		if (phy_link_if_i.oePhy === 1'b1 && phy_link_if_i.ctl === CTL_RECEIVE
			&& prevCtl === CTL_RECEIVE && prevD === D_DATA_ON && phy_link_if_i.d !== D_DATA_ON)
			spdQ.push_back(phy_link_if_i.d);
		prevCtl = phy_link_if_i.ctl;
		prevD = phy_link_if_i.d;
		prevOe = phy_link_if_i.oePhy;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] expV, input logic [15:0] gotV);
		nTests++;
		if (gotV !== expV)
		begin
			$display("wrong value %s expected %h seen %h", what, expV, gotV);
			miscompares++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge pclk);
	endtask
	task automatic clear_mon();
		rxGot.delete();
		txGot.delete();
		spdQ.delete();
		statBits.delete();
		statToRx = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic rx_packet(input speed_t sp, input logic [7:0] code, input int nOn);
		int rx0;
		clear_mon();
		rx0 = rxCnt;
		rxPrefix = 1'b1;
		tick(nOn);
		rxSpeedIn = sp;
		rxSpeedValid = 1'b1;
		tick(1);
		rxSpeedValid = 1'b0;
		rxDataValid = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			rxDataIn = 8'ha0 + 8'(i);
			tick(1);
		end
		rxPrefix = 1'b0;
		rxDataValid = 1'b0;
		tick(8);
		check("speed code", 16'(code), 16'(spdQ[0]));
		check("rx speed", 16'(sp), 16'(lRxSpeed));
		check("rx done", 16'h0001, 16'(rxCnt - rx0));
		check("rx count", (sp == SPD_S400) ? 16'h0000 : 16'h0003, 16'(rxGot.size()));
		for (int i = 0; i < 3 && sp != SPD_S400; i++)
			check("rx byte", 16'(8'ha0 + 8'(i)), 16'(rxGot[i]));
	endtask

	task automatic rx_null_status();
		clear_mon();
		rxPrefix = 1'b1;
		tick(2);
		rxPrefix = 1'b0;
		tick(6);
		check("null speed codes", 16'h0000, 16'(spdQ.size()));
		check("null bytes", 16'h0000, 16'(rxGot.size()));
		statWord = 16'h0009;
		for (int n = 0; n < 2; n++)
		begin
			statLong = 1'(n);
			for (int i = 0; i < 50 && statReady !== 1'b1; i++)
				tick(1);
			statStart = 1'b1;
			tick(1);
			statStart = 1'b0;
			tick(2 + 4 * (1 - n));
		end
		check("status cycles", 16'h0004, 16'(statBits.size()));
		for (int i = 0; i < 4; i++)
			check("status bits", 16'(statWord[2 * (i % 2) +: 2]), 16'(statBits[i]));
		rxPrefix = 1'b1;
		tick(3);
		rxPrefix = 1'b0;
		tick(8);
		check("status to receive", 16'h0001, 16'(statToRx));
	endtask

	task automatic tx_run(input speed_t sp1, input speed_t sp2, input logic m, input logic c,
		input logic two);
		int done0;
		int idx;
		clear_mon();
		done0 = doneCnt;
		idx = 0;
		msc = m;
		grantSpeed = sp1;
		lTxSpeed = sp1;
		txConcat = c;
		txNextSpeed = sp2;
		@(negedge core_clk);
		txGo = 1'b1;
		@(negedge core_clk);
		txGo = 1'b0;
		for (int i = 0; i < 100 && busRequest !== 1'b1; i++)
			tick(1);
		check("bus request", 16'h0001, 16'(busRequest));
		check("busy", 16'h0001, 16'(busy));
		arbWon = 1'b1;
		tick(1);
		arbWon = 1'b0;
		for (int k = 0; k < (two ? 2 : 1); k++)
		begin
			for (int i = 0; i < 100 && txReady !== 1'b1; i++)
				tick(1);
			tick(3);
			check("data prefix", 16'h0001, 16'(txPrefix));
			lTxValid = 1'b1;
			for (int i = 0; i < 3; i++)
			begin
				lTxData = 8'hc0 + 8'(idx++);
				txLast = (i == 2);
				tick(1);
			end
			lTxValid = 1'b0;
			txLast = 1'b0;
			for (int i = 0; i < 100 && txReady !== 1'b0; i++)
				tick(1);
		end
		for (int i = 0; i < 300 && doneCnt == done0; i++)
			tick(1);
		check("tx done", 16'h0001, 16'(doneCnt - done0));
		check("busy", 16'h0000, 16'(busy));
		check("tx beats", 16'(idx), 16'(txGot.size()));
		for (int i = 0; i < idx; i++)
			check("tx byte", 16'(8'hc0 + 8'(i)), 16'(txGot[i]));
		check("tx speed", 16'((two && m) ? sp2 : sp1), 16'(pTxSpeed));
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		{nrst, statStart, statLong, rxPrefix, rxSpeedValid, rxDataValid, arbWon} = 7'h00;
		{msc, txGo, lTxValid, txLast, txConcat, prevOe} = 6'h00;
		{statWord, rxDataIn, lTxData, prevD, prevCtl} = 42'h0;
		{rxSpeedIn, grantSpeed, lTxSpeed, txNextSpeed} = {SPD_S100, SPD_S100, SPD_S100, SPD_S100};
		{miscompares, nTests, doneCnt, rxCnt} = 128'h0;
		statToRx = 1'b0;
		tick(3);
		nrst = 1'b1;
		tick(6);
		rx_packet(SPD_S100, SPD_CODE100, 1);
		rx_packet(SPD_S200, SPD_CODE200, 3);
		rx_packet(SPD_S400, SPD_CODE400, 1);
		rx_null_status();
		tx_run(SPD_S200, SPD_S200, 1'b0, 1'b0, 1'b0);
		tx_run(SPD_S200, SPD_S400, 1'b1, 1'b1, 1'b1);
		tx_run(SPD_S200, SPD_S400, 1'b0, 1'b1, 1'b1);
		tx_run(SPD_S400, SPD_S100, 1'b1, 1'b1, 1'b0);
		report_and_stop();
	end
	initial
	begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		report_and_stop();
	end
endmodule // phy_link_packet_handshake_tb
